// >>> verilog/rpc_map.vh
// Purpose: constants of the reset and power-down controller
// Assumes: register index = documented offset, byte address = 4 * index
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef RPC_MAP_VH
`define RPC_MAP_VH

`define RPC_CLK_MHZ 50
`define RPC_CLK_KHZ 50000

// Register indices
`define RPC_IDX_SPCFG 14'h000
`define RPC_IDX_PLLPD 14'h010
`define RPC_IDX_DRV_FIRST 14'h0f0
`define RPC_IDX_DRV_LAST 14'h0fd
`define RPC_IDX_CH0 14'h192
`define RPC_IDX_CH1 14'h195
`define RPC_IDX_CH2 14'h198
`define RPC_IDX_CH3 14'h19b
`define RPC_IDX_DIST 14'h230
`define RPC_IDX_UPDATE 14'h232
`define RPC_IDX_RELOAD 14'hb02
`define RPC_IDX_STATUS 14'h300

// Field positions
`define RPC_BIT_SRST_HI 5
`define RPC_BIT_SRST_LO 2
`define RPC_BIT_DRV_PD 0
`define RPC_BIT_CH_PD 2
`define RPC_BIT_SOFT_SYNC 0
`define RPC_BIT_DIST_PD 1
`define RPC_BIT_UPDATE 0
`define RPC_BIT_RELOAD 1

// PLL power-down field encodings
`define RPC_PLL_NORMAL 2'h0
`define RPC_PLL_ASYNC 2'h1
`define RPC_PLL_SYNC 2'h3

// Reset values
`define RPC_DEF_SPCFG 8'h00
`define RPC_DEF_PLLPD 2'h0
`define RPC_DEF_DRV_PD 14'h0000
`define RPC_DEF_CH_PD 4'h0
`define RPC_DEF_DIST 2'h0

// Times and derived counts
`define RPC_T_START_NS 2000
`define RPC_T_LOAD_MS 20
`define RPC_T_POR_MS 70
`define RPC_CYC_START (`RPC_T_START_NS * `RPC_CLK_MHZ / 1000)
`define RPC_CYC_LOAD (`RPC_CLK_KHZ * `RPC_T_LOAD_MS)
`define RPC_CYC_POR (`RPC_CLK_KHZ * `RPC_T_POR_MS)

// AXI responses
`define RPC_RESP_OKAY 2'h0
`define RPC_RESP_SLVERR 2'h2

`endif

// >>> verilog/rpc_sync.v
// Purpose: two-flop synchroniser for a level input
// Assumes: the first flop is read by the second only
// Notes: RST_VAL is the idle level of the pin
`timescale 1ns/1ps
`default_nettype none

module rpc_sync #(
  parameter RST_VAL = 1'b1
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Level in and out
  input wire d_in,
  output wire q_out
);

  reg meta_reg;
  reg q_reg;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= d_in;
      q_reg <= meta_reg;
    end
  end

  assign q_out = q_reg;

endmodule // rpc_sync

`default_nettype wire

// >>> verilog/rpc_top.v
// Purpose: reset, reload and power-down control of a clock generator
// Assumes: AXI4-Lite register access, one 50 MHz clock, 8-bit registers
// Notes: configuration writes land in a staging copy and go live on update
//
// Behaviour
// - Hard reset pin pulse resets chip; restore from store or defaults by pin.
// - Every hard reset also runs an output alignment.
// - Store inactive: outputs toggle about 2 us after hard reset.
// - Store active: outputs toggle about 20 ms after hard reset release.
// - Bits 5 and 2 of register 0x000 set: soft reset, all but 0x000.
// - Soft reset bits self-clear at the end; outputs static meanwhile.
// - Reload bit reloads store only when source pin is 1; 20 ms restart.
// - Sleep pin low powers down; wake resumes with current registers.
// - Sleep turns off PLL, VCO, input buffer, dividers; drivers safe off.
// - Register port keeps working during sleep.
// - Output gating avoids runt pulses entering or leaving sleep.
// - Field 0x010[1:0] picks async or sync PLL power-down.
// - Sync mode shuts PLL at first charge pump event after update.
// - 0x230[1] set removes distribution bias.
// - Bit 0 of 0x0F0 to 0x0FD powers down each driver.
// - Channel bit 2 powers down divider and its attached drivers.
// - Alignment and power-down writes take effect on 0x232[0] update.
// - Power-on restores, aligns and starts outputs after about 70 ms.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rpc_map.vh"

module rpc_top #(
  parameter POR_CYCLES = `RPC_CYC_POR,
  parameter LOAD_CYCLES = `RPC_CYC_LOAD
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write channels
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Device pins
  input wire hard_reset_n,
  input wire chip_sleep_n,
  input wire cfg_src_sel,
  // Charge pump event, one-cycle pulse
  input wire cp_event,
  // Nonvolatile image
  input wire [1:0] nv_pll_pd,
  input wire [13:0] nv_drv_pd,
  input wire [3:0] nv_ch_pd,
  input wire [1:0] nv_dist,
  // Power and output controls
  output reg out_gate,
  output reg align_hold,
  output reg pll_pd,
  output reg core_pd,
  output reg dist_pd,
  output reg [3:0] ch_pd,
  output reg [13:0] drv_pd,
  output reg cmos_tristate,
  output reg soft_sync
);

  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;
  localparam [21:0] START_CYC = `RPC_CYC_START;

  wire rst_pin_s;
  wire sleep_n_s;

  reg [2:0] state_reg;
  reg [21:0] cnt_reg;
  reg [7:0] spcfg_reg;
  reg reload_reg;
  reg [1:0] pll_buf_reg;
  reg [1:0] pll_act_reg;
  reg [13:0] drv_buf_reg;
  reg [13:0] drv_act_reg;
  reg [3:0] ch_buf_reg;
  reg [3:0] ch_act_reg;
  reg [1:0] dist_buf_reg;
  reg [1:0] dist_act_reg;
  reg pll_off_reg;

  reg aw_hold_reg;
  reg [13:0] aw_idx_reg;
  reg w_hold_reg;
  reg [7:0] wdata_reg;
  reg wlane_reg;

  wire do_wr;
  wire [13:0] drv_sel;
  wire [7:0] wd;
  wire [1:0] restore_pll;
  wire [13:0] restore_drv;
  wire [3:0] restore_ch;
  wire [1:0] restore_dist;
  wire [21:0] restart_cnt;
  wire [21:0] load_cnt;
  wire [21:0] start_cnt;
  wire [21:0] por_cnt;
  wire soft_hit;
  wire reload_hit;
  wire [13:0] drv_eff;

  // Reset and sleep pins are synchronised so they release cleanly
  rpc_sync #(.RST_VAL(1'b1)) u_sync_rst (
    .aclk(aclk),
    .aresetn(aresetn),
    .d_in(hard_reset_n),
    .q_out(rst_pin_s)
  );

  rpc_sync #(.RST_VAL(1'b1)) u_sync_sleep (
    .aclk(aclk),
    .aresetn(aresetn),
    .d_in(chip_sleep_n),
    .q_out(sleep_n_s)
  );

  assign load_cnt = LOAD_CYCLES[21:0];
  assign start_cnt = START_CYC;
  assign por_cnt = POR_CYCLES[21:0];

  // Source of restored settings follows the select pin
  assign restore_pll = cfg_src_sel ? nv_pll_pd : `RPC_DEF_PLLPD;
  assign restore_drv = cfg_src_sel ? nv_drv_pd : `RPC_DEF_DRV_PD;
  assign restore_ch = cfg_src_sel ? nv_ch_pd : `RPC_DEF_CH_PD;
  assign restore_dist = cfg_src_sel ? nv_dist : `RPC_DEF_DIST;
  // Loading the store costs far longer than a default restore
  assign restart_cnt = cfg_src_sel ? load_cnt : start_cnt;

  // Register port
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_wr = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  assign wd = wdata_reg;
  assign drv_sel = aw_idx_reg - `RPC_IDX_DRV_FIRST;

  assign soft_hit = do_wr & wlane_reg & (aw_idx_reg == `RPC_IDX_SPCFG) &
    wd[`RPC_BIT_SRST_HI] & wd[`RPC_BIT_SRST_LO];
  assign reload_hit = do_wr & wlane_reg &
    (aw_idx_reg == `RPC_IDX_RELOAD) & wd[`RPC_BIT_RELOAD] &
    cfg_src_sel;

  function is_mapped;
    input [13:0] idx;
    begin
      is_mapped = (idx == `RPC_IDX_SPCFG) || (idx == `RPC_IDX_PLLPD) ||
        ((idx >= `RPC_IDX_DRV_FIRST) && (idx <= `RPC_IDX_DRV_LAST)) ||
        (idx == `RPC_IDX_CH0) || (idx == `RPC_IDX_CH1) ||
        (idx == `RPC_IDX_CH2) || (idx == `RPC_IDX_CH3) ||
        (idx == `RPC_IDX_DIST) || (idx == `RPC_IDX_UPDATE) ||
        (idx == `RPC_IDX_RELOAD) || (idx == `RPC_IDX_STATUS);
    end
  endfunction

  function [7:0] rd_value;
    input [13:0] idx;
    reg [13:0] d;
    begin
      d = idx - `RPC_IDX_DRV_FIRST;
      rd_value = 8'h00;
      if (idx == `RPC_IDX_SPCFG)
        rd_value = spcfg_reg;
      else if (idx == `RPC_IDX_PLLPD)
        rd_value = {6'h00, pll_buf_reg};
      else if ((idx >= `RPC_IDX_DRV_FIRST) && (idx <= `RPC_IDX_DRV_LAST))
        rd_value = {7'h00, drv_buf_reg[d[3:0]]};
      else if (idx == `RPC_IDX_CH0)
        rd_value = {5'h00, ch_buf_reg[0], 2'h0};
      else if (idx == `RPC_IDX_CH1)
        rd_value = {5'h00, ch_buf_reg[1], 2'h0};
      else if (idx == `RPC_IDX_CH2)
        rd_value = {5'h00, ch_buf_reg[2], 2'h0};
      else if (idx == `RPC_IDX_CH3)
        rd_value = {5'h00, ch_buf_reg[3], 2'h0};
      else if (idx == `RPC_IDX_DIST)
        rd_value = {6'h00, dist_buf_reg};
      else if (idx == `RPC_IDX_RELOAD)
        rd_value = {6'h00, reload_reg, 1'b0};
      else if (idx == `RPC_IDX_STATUS)
        rd_value = {3'h0, pll_off_reg, ~sleep_n_s, state_reg};
    end
  endfunction

  // Write address and data may arrive in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      aw_idx_reg <= 14'h0000;
      w_hold_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wlane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RPC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RPC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[15:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end
      if (do_wr)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_idx_reg) ? `RPC_RESP_OKAY :
          `RPC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Reads are served in any power state
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_value(s_axi_araddr[15:2])};
        s_axi_rresp <= is_mapped(s_axi_araddr[15:2]) ? `RPC_RESP_OKAY :
          `RPC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers and reset sequencer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_HOLD;
      cnt_reg <= 22'h000000;
      spcfg_reg <= `RPC_DEF_SPCFG;
      reload_reg <= 1'b0;
      pll_buf_reg <= `RPC_DEF_PLLPD;
      pll_act_reg <= `RPC_DEF_PLLPD;
      drv_buf_reg <= `RPC_DEF_DRV_PD;
      drv_act_reg <= `RPC_DEF_DRV_PD;
      ch_buf_reg <= `RPC_DEF_CH_PD;
      ch_act_reg <= `RPC_DEF_CH_PD;
      dist_buf_reg <= `RPC_DEF_DIST;
      dist_act_reg <= `RPC_DEF_DIST;
    end
    else if (!rst_pin_s || (state_reg == ST_HOLD))
    begin
      // Hard reset, and the first cycle after power-on
      spcfg_reg <= `RPC_DEF_SPCFG;
      reload_reg <= 1'b0;
      pll_buf_reg <= restore_pll;
      pll_act_reg <= restore_pll;
      drv_buf_reg <= restore_drv;
      drv_act_reg <= restore_drv;
      ch_buf_reg <= restore_ch;
      ch_act_reg <= restore_ch;
      dist_buf_reg <= restore_dist;
      dist_act_reg <= restore_dist;
      state_reg <= rst_pin_s ? ST_WAIT : ST_HOLD;
      // Power-on keeps its longer count loaded while leaving hold
      if (!rst_pin_s)
        cnt_reg <= restart_cnt;
      else if (cnt_reg == 22'h000000)
        cnt_reg <= por_cnt;
    end
    else if (soft_hit || reload_hit)
    begin
      // Register 0x000 itself is left as written
      if (soft_hit)
        spcfg_reg <= wd;
      if (reload_hit)
        reload_reg <= 1'b1;
      pll_buf_reg <= reload_hit ? nv_pll_pd : restore_pll;
      pll_act_reg <= reload_hit ? nv_pll_pd : restore_pll;
      drv_buf_reg <= reload_hit ? nv_drv_pd : restore_drv;
      drv_act_reg <= reload_hit ? nv_drv_pd : restore_drv;
      ch_buf_reg <= reload_hit ? nv_ch_pd : restore_ch;
      ch_act_reg <= reload_hit ? nv_ch_pd : restore_ch;
      dist_buf_reg <= reload_hit ? nv_dist : restore_dist;
      dist_act_reg <= reload_hit ? nv_dist : restore_dist;
      state_reg <= ST_WAIT;
      cnt_reg <= reload_hit ? load_cnt : restart_cnt;
    end
    else
    begin
      case (state_reg)
        ST_WAIT:
        begin
          if (cnt_reg <= 22'h000001)
          begin
            state_reg <= ST_RUN;
            cnt_reg <= 22'h000000;
            spcfg_reg[`RPC_BIT_SRST_HI] <= 1'b0;
            spcfg_reg[`RPC_BIT_SRST_LO] <= 1'b0;
            reload_reg <= 1'b0;
          end
          else
            cnt_reg <= cnt_reg - 22'h000001;
        end
        ST_RUN:
          state_reg <= ST_RUN;
        default:
          state_reg <= ST_HOLD;
      endcase
      // Staging writes work outside hard reset and hold, sleep included
      if (do_wr && wlane_reg)
      begin
        if (aw_idx_reg == `RPC_IDX_SPCFG)
          spcfg_reg <= wd;
        if (aw_idx_reg == `RPC_IDX_PLLPD)
          pll_buf_reg <= wd[1:0];
        if ((aw_idx_reg >= `RPC_IDX_DRV_FIRST) &&
            (aw_idx_reg <= `RPC_IDX_DRV_LAST))
          drv_buf_reg[drv_sel[3:0]] <= wd[`RPC_BIT_DRV_PD];
        if (aw_idx_reg == `RPC_IDX_CH0)
          ch_buf_reg[0] <= wd[`RPC_BIT_CH_PD];
        if (aw_idx_reg == `RPC_IDX_CH1)
          ch_buf_reg[1] <= wd[`RPC_BIT_CH_PD];
        if (aw_idx_reg == `RPC_IDX_CH2)
          ch_buf_reg[2] <= wd[`RPC_BIT_CH_PD];
        if (aw_idx_reg == `RPC_IDX_CH3)
          ch_buf_reg[3] <= wd[`RPC_BIT_CH_PD];
        if (aw_idx_reg == `RPC_IDX_DIST)
          dist_buf_reg <= wd[1:0];
        // Staged values go live together on update
        if ((aw_idx_reg == `RPC_IDX_UPDATE) && wd[`RPC_BIT_UPDATE])
        begin
          pll_act_reg <= pll_buf_reg;
          drv_act_reg <= drv_buf_reg;
          ch_act_reg <= ch_buf_reg;
          dist_act_reg <= dist_buf_reg;
        end
      end
    end
  end

  // PLL off state; sync mode waits for the charge pump to avoid a jump
  always @(posedge aclk)
  begin
    if (!aresetn)
      pll_off_reg <= 1'b0;
    else if (pll_act_reg == `RPC_PLL_ASYNC)
      pll_off_reg <= 1'b1;
    else if (pll_act_reg == `RPC_PLL_SYNC)
    begin
      if (cp_event)
        pll_off_reg <= 1'b1;
    end
    else
      pll_off_reg <= 1'b0;
  end

  // A channel takes its three drivers down with it
  genvar g;
  generate
    for (g = 0; g < 14; g = g + 1)
    begin : g_drv
      if (g < 12)
        assign drv_eff[g] = drv_act_reg[g] | ch_act_reg[g / 3];
      else
        assign drv_eff[g] = drv_act_reg[g];
    end
  endgenerate

  // Outputs registered so gate edges never cut a clock pulse short
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_gate <= 1'b0;
      align_hold <= 1'b1;
      pll_pd <= 1'b1;
      core_pd <= 1'b1;
      dist_pd <= 1'b0;
      ch_pd <= 4'hf;
      drv_pd <= 14'h3fff;
      cmos_tristate <= 1'b1;
      soft_sync <= 1'b0;
    end
    else
    begin
      out_gate <= (state_reg == ST_RUN) & sleep_n_s;
      align_hold <= (state_reg != ST_RUN);
      pll_pd <= pll_off_reg | ~sleep_n_s;
      core_pd <= ~sleep_n_s;
      dist_pd <= dist_act_reg[`RPC_BIT_DIST_PD];
      ch_pd <= ch_act_reg | {4{~sleep_n_s}};
      drv_pd <= drv_eff | {14{~sleep_n_s}};
      cmos_tristate <= ~sleep_n_s;
      soft_sync <= dist_act_reg[`RPC_BIT_SOFT_SYNC];
    end
  end

endmodule // rpc_top

`default_nettype wire

// >>> tb/rpc_far_model.sv
// Purpose: far side model: stored settings image and charge pump
// Assumes: one clock shared with the controller
// Notes: the image is fixed by parameter, pump pulses every 16 cycles
`timescale 1ns/1ps
`default_nettype none
module rpc_far_model #(
  parameter logic [13:0] NV_DRV = 14'h0000
) (
  // Clock
  input wire logic aclk,
  // Pump enable from the bench
  input wire logic cp_en,
  // Pump event and stored image
  output logic cp_event,
  output logic [1:0] nv_pll_pd,
  output logic [13:0] nv_drv_pd,
  output logic [3:0] nv_ch_pd,
  output logic [1:0] nv_dist
);
  logic [3:0] cnt_reg = 4'h0;
  assign nv_pll_pd = 2'h0;
  assign nv_drv_pd = NV_DRV;
  assign nv_ch_pd = 4'h0;
  assign nv_dist = 2'h0;
  // One-cycle pulse, so a sync power-down waits up to 16 cycles
  always @(posedge aclk)
  begin
    cnt_reg <= cnt_reg + 4'h1;
    cp_event <= cp_en && (cnt_reg == 4'hf);
  end
endmodule // rpc_far_model
`default_nettype wire

// >>> tb/rpc_chk_assertions.sv
// Purpose: port checks of the reset and power-down controller
// Assumes: one clock, synchronous active-low reset
// Notes: pin waits allow for the two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module rpc_chk #(
  parameter int POR_CYCLES = 50,
  parameter int LOAD_CYCLES = 40
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  // Pins
  input wire logic hard_reset_n,
  input wire logic chip_sleep_n,
  input wire logic cfg_src_sel,
  // Controls
  input wire logic out_gate,
  input wire logic align_hold,
  input wire logic pll_pd,
  input wire logic core_pd,
  input wire logic [3:0] ch_pd,
  input wire logic [13:0] drv_pd,
  input wire logic cmos_tristate
);
  localparam int LHI = LOAD_CYCLES + 12;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_hard;
    !hard_reset_n [*6] |-> !out_gate && align_hold;
  endproperty
  a_hard: assert property (p_hard)
    else $error("hard reset left outputs running");
  property p_start0;
    $rose(hard_reset_n) && !cfg_src_sel |-> ##[96:112] out_gate;
  endproperty
  a_start0: assert property (p_start0)
    else $error("outputs late after hard reset");
  property p_start1;
    $rose(hard_reset_n) && cfg_src_sel |-> ##[LOAD_CYCLES:LHI] out_gate;
  endproperty
  a_start1: assert property (p_start1)
    else $error("outputs late after image load");
  property p_static;
    out_gate |-> !align_hold;
  endproperty
  a_static: assert property (p_static)
    else $error("outputs toggle while held");
  property p_sleep;
    !chip_sleep_n [*6] |-> !out_gate && core_pd && cmos_tristate;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep did not power down");
  property p_sleep_drv;
    !chip_sleep_n [*6] |-> pll_pd && ch_pd == 4'hf && drv_pd == 14'h3fff;
  endproperty
  a_sleep_drv: assert property (p_sleep_drv)
    else $error("sleep left a driver on");
  property p_chan;
    (ch_pd[0] -> &drv_pd[2:0]) && (ch_pd[1] -> &drv_pd[5:3]) &&
    (ch_pd[2] -> &drv_pd[8:6]) && (ch_pd[3] -> &drv_pd[11:9]);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel down but driver on");
  property p_bus;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_bus: assert property (p_bus)
    else $error("write got no response");
  c_sleep: cover property (!chip_sleep_n [*6]);
  c_load: cover property ($rose(hard_reset_n) && cfg_src_sel);
  c_run: cover property ($rose(out_gate));
endmodule // rpc_chk
bind rpc_top rpc_chk #(
  .POR_CYCLES(POR_CYCLES),
  .LOAD_CYCLES(LOAD_CYCLES)
) i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .hard_reset_n, .chip_sleep_n,
  .cfg_src_sel, .out_gate, .align_hold, .pll_pd, .core_pd, .ch_pd,
  .drv_pd, .cmos_tristate
);
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench of the reset and power-down controller
// Assumes: short power-on and load counts, image fixed in the far model
// Notes: outputs sampled at the falling edge, inputs driven after rising
`timescale 1ns/1ps
`default_nettype none
`include "rpc_map.vh"
module tb_top;
  localparam int POR = 50;
  localparam int LOAD = 40;
  localparam logic [13:0] NV_DRV = 14'h2a5b;
  localparam int DRV = `RPC_IDX_DRV_FIRST;
  localparam int RLD = `RPC_IDX_RELOAD;
  localparam int UPD = `RPC_IDX_UPDATE;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0;
  logic [15:0] araddr = 16'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic hard_reset_n = 1'b1;
  logic chip_sleep_n = 1'b1;
  logic cfg_src_sel = 1'b0;
  logic cp_en = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, cp_event;
  wire out_gate, align_hold, pll_pd, core_pd, dist_pd, cmos_tristate;
  wire [1:0] bresp, rresp, nv_pll_pd, nv_dist;
  wire [31:0] rdata;
  wire [3:0] ch_pd, nv_ch_pd;
  wire [13:0] drv_pd, nv_drv_pd;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] mdl [int];
  always #10 aclk = ~aclk;
  rpc_top #(.POR_CYCLES(POR), .LOAD_CYCLES(LOAD)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hard_reset_n, .chip_sleep_n, .cfg_src_sel,
    .cp_event, .nv_pll_pd, .nv_drv_pd, .nv_ch_pd, .nv_dist, .out_gate,
    .align_hold, .pll_pd, .core_pd, .dist_pd, .ch_pd, .drv_pd,
    .cmos_tristate, .soft_sync()
  );
  rpc_far_model #(.NV_DRV(NV_DRV)) i_far (
    .aclk, .cp_en, .cp_event, .nv_pll_pd, .nv_drv_pd, .nv_ch_pd, .nv_dist
  );
  task automatic stop_test();
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ck(input string n, input logic [31:0] e,
                    input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] mv(input int i);
    return mdl.exists(i) ? mdl[i] : 8'h00;
  endfunction
  // Drivers of a powered-down channel count as down too
  function automatic logic [13:0] exp_drv();
    logic [13:0] e;
    logic [7:0] d;
    logic [7:0] c;
    for (int k = 0; k < 14; k++)
    begin
      d = mv(DRV + k);
      c = mv(`RPC_IDX_CH0 + 3 * (k / 3));
      e[k] = d[0] | (k < 12 && c[2]);
    end
    return e;
  endfunction
  task automatic wr(input int i, input logic [7:0] d,
                    input logic [1:0] er);
    logic ha;
    logic hw;
    logic hb;
    logic [1:0] r;
    ha = 1'b0;
    hw = 1'b0;
    hb = 1'b0;
    @(posedge aclk);
    awaddr <= {i[13:0], 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb)
    begin
      @(negedge aclk);
      ha = ha | (awvalid & awready);
      hw = hw | (wvalid & wready);
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    ck("bresp", {30'h0, er}, {30'h0, r});
    if (er === 2'h0 && i != UPD && i != RLD)
      mdl[i] = d;
  endtask
  task automatic rd(input int i, input logic [1:0] er);
    logic h;
    logic a;
    h = 1'b0;
    @(posedge aclk);
    araddr <= {i[13:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!h)
    begin
      @(negedge aclk);
      h = rvalid;
      if (h)
      begin
        ck("rdata", {24'h0, mv(i)}, rdata);
        ck("rresp", {30'h0, er}, {30'h0, rresp});
      end
      a = arvalid & arready;
      @(posedge aclk);
      if (a)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic upd();
    wr(UPD, 8'h01, 2'h0);
    @(negedge aclk);
  endtask
  // Bounded wait on out_gate or pll_pd, then compare
  task automatic wt(input logic s, input logic v, input int lim);
    int n;
    n = 0;
    @(negedge aclk);
    while ((s ? pll_pd : out_gate) !== v && n < lim)
    begin
      @(negedge aclk);
      n++;
    end
    ck(s ? "pll_pd" : "out_gate", {31'h0, v}, {31'h0, s ? pll_pd : out_gate});
  endtask
  initial
  begin
    int k;
    void'($urandom(18));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wt(0, 1'b1, POR + 20);
    ck("drv_pd", 14'h0, drv_pd);
    for (k = 0; k < 14; k++)
      wr(DRV + k, 8'($urandom % 2), 2'h0);
    for (k = 0; k < 14; k++)
      rd(DRV + k, 2'h0);
    @(negedge aclk);
    ck("drv_pd", 14'h0, drv_pd);
    upd();
    ck("drv_pd", exp_drv(), drv_pd);
    wr(`RPC_IDX_CH0, 8'h04, 2'h0);
    wr(`RPC_IDX_CH3, 8'h04, 2'h0);
    wr(`RPC_IDX_DIST, 8'h02, 2'h0);
    upd();
    ck("ch_pd", 4'h9, ch_pd);
    ck("drv_pd", exp_drv(), drv_pd);
    ck("dist_pd", 1'b1, dist_pd);
    wr(14'h3ff, 8'h5a, 2'h2);
    rd(14'h3ff, 2'h2);
    wr(`RPC_IDX_PLLPD, 8'h01, 2'h0);
    upd();
    wt(1, 1'b1, 3);
    wr(`RPC_IDX_PLLPD, 8'h00, 2'h0);
    upd();
    wt(1, 1'b0, 3);
    wr(`RPC_IDX_PLLPD, 8'h03, 2'h0);
    upd();
    repeat (8) @(negedge aclk);
    ck("pll_pd", 1'b0, pll_pd);
    cp_en <= 1'b1;
    wt(1, 1'b1, 40);
    rd(`RPC_IDX_PLLPD, 2'h0);
    @(posedge aclk);
    chip_sleep_n <= 1'b0;
    repeat (6) @(negedge aclk);
    ck("core_pd", 1'b1, core_pd);
    ck("tristate", 1'b1, cmos_tristate);
    wr(DRV, mv(DRV) ^ 8'h01, 2'h0);
    wr(`RPC_IDX_PLLPD, 8'h00, 2'h0);
    upd();
    rd(DRV, 2'h0);
    @(posedge aclk);
    chip_sleep_n <= 1'b1;
    wt(0, 1'b1, 10);
    ck("drv_pd", exp_drv(), drv_pd);
    wr(`RPC_IDX_SPCFG, 8'h24, 2'h0);
    wt(0, 1'b0, 5);
    wt(0, 1'b1, 250);
    mdl.delete();
    ck("drv_pd", exp_drv(), drv_pd);
    rd(`RPC_IDX_SPCFG, 2'h0);
    rd(`RPC_IDX_CH0, 2'h0);
    wr(RLD, 8'h02, 2'h0);
    repeat (4) @(negedge aclk);
    ck("out_gate", 1'b1, out_gate);
    rd(RLD, 2'h0);
    for (k = 0; k < 2; k++)
    begin
      @(posedge aclk);
      cfg_src_sel <= k[0];
      hard_reset_n <= 1'b0;
      repeat (7) @(negedge aclk);
      ck("align_hold", 1'b1, align_hold);
      @(posedge aclk);
      hard_reset_n <= 1'b1;
      wt(0, 1'b1, LOAD + 150);
      mdl.delete();
      for (int i = 0; i < 14; i++)
        mdl[DRV + i] = {7'h0, NV_DRV[i] & k[0]};
      ck("drv_pd", exp_drv(), drv_pd);
      rd(DRV + 5, 2'h0);
    end
    wr(DRV, mv(DRV) ^ 8'h01, 2'h0);
    wr(RLD, 8'h02, 2'h0);
    wt(0, 1'b0, 5);
    wt(0, 1'b1, LOAD + 20);
    mdl[DRV] = {7'h0, NV_DRV[0]};
    rd(DRV, 2'h0);
    mdl[`RPC_IDX_STATUS] = 8'h04;
    rd(`RPC_IDX_STATUS, 2'h0);
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
